// ===== verilog/nfero_top.v
// Near front-end readout control: capture, timestamp, buffer, suppress, read out
`timescale 1ns/1ps
`include "nfero_defines.vh"
module nfero_top #(
  parameter CHAN_N = `NFERO_CHAN_N,
  parameter PD_N = `NFERO_PD_N,
  parameter BURST_LEN = `NFERO_BURST_LEN,
  parameter FIFO_DEPTH = `NFERO_FIFO_DEPTH,
  parameter TS_W = `NFERO_TS_W
) (
  input wire i_clk_sys, // RF clock
  input wire i_arst_n, // Asynchronous reset, active low
  input wire [1:0] i_mode, // Acquisition mode select
  input wire i_spill, // Accelerator spill in progress (pin)
  input wire [PD_N-1:0] i_dynode_trig, // Discriminated dynode triggers (pins)
  input wire [CHAN_N*`NFERO_RANGE_W-1:0] i_range_code, // Range codes per channel
  input wire [CHAN_N*`NFERO_CONV_W-1:0] i_conv_value, // Flash converter values per channel
  input wire [`NFERO_SAMPLE_W-1:0] i_threshold, // Zero-suppression threshold on range and value
  input wire i_out_ready, // Readout board accepts word
  output reg o_out_valid, // Output word valid
  output reg [`NFERO_SAMPLE_W-1:0] o_out_sample, // Capacitor set, range code, converter value
  output reg [7:0] o_out_chan, // Channel number of the word
  output reg [TS_W-1:0] o_out_ts, // RF bucket timestamp
  output reg o_overflow, // Sticky: a sample set was dropped for lack of room
  output reg o_busy // Readout transfer in progress
);
  localparam SET_W = TS_W + CHAN_N*`NFERO_SAMPLE_W;
  localparam ST_IDLE = 3'b001;
  localparam ST_XFER = 3'b010;
  localparam ST_HOLD = 3'b100;

  reg rst_s1_reg;
  reg rst_s2_reg;
  wire rst_n;
  reg spill_s1_reg;
  reg spill_s2_reg;
  reg spill_d_reg;
  reg [PD_N-1:0] trig_s1_reg;
  reg [PD_N-1:0] trig_s2_reg;
  reg [TS_W-1:0] ts_reg;
  reg [`NFERO_CAPACITOR_SET_ID_W-1:0] capacitor_set_id_reg;
  reg [3:0] burst_reg;
  reg [PD_N-1:0] pd_sel_reg;
  reg [2:0] state_reg;
  reg [7:0] chan_reg;
  reg [SET_W-1:0] set_reg;
  reg [PD_N-1:0] set_pd_reg;
  reg keep;
  reg [PD_N-1:0] pd_mask;
  wire spill_end;
  wire fifo_wr_ready;
  wire fifo_rd_valid;
  wire [SET_W+PD_N-1:0] fifo_rd_data;
  wire [SET_W+PD_N-1:0] fifo_wr_data;
  wire [CHAN_N*`NFERO_SAMPLE_W-1:0] samples;
  wire fifo_rd_ready;
  wire [`NFERO_SAMPLE_W-1:0] cur_sample;
  wire chan_keep;

  // Extracts the 13-bit word of one channel from a packed set
  function [`NFERO_SAMPLE_W-1:0] pick;
    input [CHAN_N*`NFERO_SAMPLE_W-1:0] bus;
    input [7:0] idx;
    begin
      pick = bus[idx*`NFERO_SAMPLE_W +: `NFERO_SAMPLE_W];
    end
  endfunction

  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      spill_s1_reg <= 1'b0;
      spill_s2_reg <= 1'b0;
      spill_d_reg <= 1'b0;
      trig_s1_reg <= {PD_N{1'b0}};
      trig_s2_reg <= {PD_N{1'b0}};
    end else begin
      spill_s1_reg <= i_spill;
      spill_s2_reg <= spill_s1_reg;
      spill_d_reg <= spill_s2_reg;
      trig_s1_reg <= i_dynode_trig;
      trig_s2_reg <= trig_s1_reg;
    end
  end
  assign spill_end = spill_d_reg && !spill_s2_reg;

  // Bucket counter and capacitor set phase run every RF cycle
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ts_reg <= {TS_W{1'b0}};
      capacitor_set_id_reg <= {`NFERO_CAPACITOR_SET_ID_W{1'b0}};
    end else begin
      ts_reg <= ts_reg + 1'b1;
      capacitor_set_id_reg <= capacitor_set_id_reg + 1'b1;
    end
  end

  // Pack capacitor set, range code and converter value per channel
  genvar g;
  generate
    for (g = 0; g < CHAN_N; g = g + 1) begin : g_pack
      assign samples[g*`NFERO_SAMPLE_W +: `NFERO_SAMPLE_W] = {capacitor_set_id_reg,
        i_range_code[g*`NFERO_RANGE_W +: `NFERO_RANGE_W],
        i_conv_value[g*`NFERO_CONV_W +: `NFERO_CONV_W]};
    end
  endgenerate

  // Storage decision per mode
  always @* begin
    keep = 1'b0;
    pd_mask = {PD_N{1'b0}};
    case (i_mode)
      `NFERO_MODE_SINGLE: begin
        keep = spill_s2_reg;
        pd_mask = {PD_N{1'b1}};
      end
      `NFERO_MODE_COSMIC: begin
        keep = !spill_s2_reg && (trig_s2_reg != {PD_N{1'b0}});
        pd_mask = trig_s2_reg;
      end
      `NFERO_MODE_RESON: begin
        keep = spill_s2_reg && ((trig_s2_reg != {PD_N{1'b0}}) || (burst_reg != 4'h0));
        pd_mask = trig_s2_reg | pd_sel_reg;
      end
      default: begin
        keep = 1'b0;
        pd_mask = {PD_N{1'b0}};
      end
    endcase
  end

  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      burst_reg <= 4'h0;
      pd_sel_reg <= {PD_N{1'b0}};
    end else if (i_mode == `NFERO_MODE_RESON && spill_s2_reg && trig_s2_reg != {PD_N{1'b0}}) begin
      burst_reg <= BURST_LEN[3:0] - 4'h1;
      pd_sel_reg <= pd_sel_reg | trig_s2_reg;
    end else if (burst_reg != 4'h0) begin
      burst_reg <= burst_reg - 4'h1;
    end else begin
      pd_sel_reg <= {PD_N{1'b0}};
    end
  end

  assign fifo_wr_data = {pd_mask, ts_reg, samples};

  nfero_fifo #(
    .WIDTH(SET_W + PD_N),
    .DEPTH(FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .i_clk(i_clk_sys),
    .i_rst_n(rst_n),
    .i_wr_data(fifo_wr_data),
    .i_wr_valid(keep),
    .o_wr_ready(fifo_wr_ready),
    .o_rd_data(fifo_rd_data),
    .o_rd_valid(fifo_rd_valid),
    .i_rd_ready(fifo_rd_ready)
  );

  // A full buffer during capture is the only loss path; flagged to the board
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_overflow <= 1'b0;
    end else if (keep && !fifo_wr_ready) begin
      o_overflow <= 1'b1;
    end
  end

  // Readout: load one set, walk channels, emit those above threshold whose photodetector bit is set in the stored mask
  assign fifo_rd_ready = (state_reg == ST_IDLE) && fifo_rd_valid &&
    (!spill_s2_reg || i_mode == `NFERO_MODE_COSMIC) && !spill_d_reg;
  assign cur_sample = pick(set_reg[CHAN_N*`NFERO_SAMPLE_W-1:0], chan_reg);
  assign chan_keep = (cur_sample[`NFERO_SAMPLE_W-`NFERO_CAPACITOR_SET_ID_W-1:0] >
    i_threshold[`NFERO_SAMPLE_W-`NFERO_CAPACITOR_SET_ID_W-1:0]) &&
    set_pd_reg[(chan_reg * PD_N / CHAN_N)];

  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      chan_reg <= 8'h00;
      set_reg <= {SET_W{1'b0}};
      set_pd_reg <= {PD_N{1'b0}};
      o_out_valid <= 1'b0;
      o_out_sample <= {`NFERO_SAMPLE_W{1'b0}};
      o_out_chan <= 8'h00;
      o_out_ts <= {TS_W{1'b0}};
      o_busy <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (fifo_rd_ready) begin
            set_reg <= fifo_rd_data[SET_W-1:0];
            set_pd_reg <= fifo_rd_data[SET_W+PD_N-1:SET_W];
            chan_reg <= 8'h00;
            o_busy <= 1'b1;
            state_reg <= ST_XFER;
          end else begin
            o_busy <= 1'b0;
          end
        end
        ST_XFER: begin
          if (chan_keep) begin
            o_out_valid <= 1'b1;
            o_out_sample <= cur_sample;
            o_out_chan <= chan_reg;
            o_out_ts <= set_reg[SET_W-1:CHAN_N*`NFERO_SAMPLE_W];
            state_reg <= ST_HOLD;
          end else if (chan_reg == CHAN_N[7:0] - 8'h01) begin
            state_reg <= ST_IDLE;
          end else begin
            chan_reg <= chan_reg + 8'h01;
          end
        end
        ST_HOLD: begin
          if (i_out_ready) begin
            o_out_valid <= 1'b0;
            if (chan_reg == CHAN_N[7:0] - 8'h01) begin
              state_reg <= ST_IDLE;
            end else begin
              chan_reg <= chan_reg + 8'h01;
              state_reg <= ST_XFER;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== pkg/nfero_defines.vh
// Constants for the near front-end readout control block
`ifndef NFERO_DEFINES_VH
`define NFERO_DEFINES_VH
`define NFERO_MODE_SINGLE 2'h0
`define NFERO_MODE_COSMIC 2'h1
`define NFERO_MODE_RESON 2'h2
`define NFERO_CAPACITOR_SET_ID_W 2
`define NFERO_RANGE_W 3
`define NFERO_CONV_W 8
`define NFERO_SAMPLE_W 13
`define NFERO_TS_W 32
`define NFERO_CHAN_N 4
`define NFERO_PD_N 2
`define NFERO_BURST_LEN 4
`define NFERO_FIFO_DEPTH 16
`define NFERO_RF_PERIOD_NS 19
`endif

// ===== verilog/nfero_fifo.v
// Synchronous valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ps
module nfero_fifo #(
  parameter WIDTH = 53,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire i_clk, // Clock
  input wire i_rst_n, // Synchronised reset, active low
  input wire [WIDTH-1:0] i_wr_data, // Write word
  input wire i_wr_valid, // Write request
  output wire o_wr_ready, // Not full
  output wire [WIDTH-1:0] o_rd_data, // Head word
  output wire o_rd_valid, // Not empty
  input wire i_rd_ready // Consumer takes head
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire do_wr;
  wire do_rd;
  assign o_wr_ready = (count_reg != DEPTH[AW:0]);
  assign o_rd_valid = (count_reg != {(AW+1){1'b0}});
  assign o_rd_data = mem[rd_ptr_reg];
  assign do_wr = i_wr_valid && o_wr_ready;
  assign do_rd = i_rd_ready && o_rd_valid;
  always @(posedge i_clk) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= i_wr_data;
    end
  end
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ===== testbench/nfero_chk.sv
// Port checker for the near front-end readout control
`timescale 1ns/1ps
module nfero_chk #(parameter TS_W = 32) (
  input wire i_clk_sys, // Clock
  input wire i_arst_n, // Reset, active low
  input wire [1:0] i_mode, // Mode
  input wire i_spill, // Spill
  input wire [12:0] i_threshold, // Threshold
  input wire i_out_ready, // Ready
  input wire o_out_valid, // Valid
  input wire [12:0] o_out_sample, // Sample word
  input wire [7:0] o_out_chan, // Channel
  input wire [TS_W-1:0] o_out_ts, // Timestamp
  input wire o_overflow, // Overflow
  input wire o_busy // Busy
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  a_word_hold: assert property (
    o_out_valid && !i_out_ready |=> o_out_valid && $stable({o_out_sample, o_out_chan, o_out_ts}))
    else $error("word changed while stalled");
  a_valid_busy: assert property (o_out_valid |-> o_busy) else $error("valid outside transfer");
  a_valid_start: assert property ($rose(o_out_valid) |-> $past(o_busy)) else $error("valid before pop");
  a_above_thr: assert property (
    o_out_valid |-> o_out_sample[10:0] > i_threshold[10:0]) else $error("suppressed word sent");
  a_chan_range: assert property (o_out_valid |-> o_out_chan < 8'h04) else $error("bad channel");
  a_capacitor_set_id_ts: assert property (
    o_out_valid |-> o_out_sample[12:11] == o_out_ts[1:0]) else $error("capacitor set out of step");
  a_spill_gate: assert property (
    i_mode == 2'h0 && i_spill [*6] |=> !$rose(o_busy)) else $error("readout during spill");
  a_ovf_sticky: assert property (o_overflow |=> o_overflow) else $error("overflow cleared");
endmodule
bind nfero_top nfero_chk #(.TS_W(TS_W)) u_nfero_chk (.*);

// ===== testbench/nfero_board_model.sv
// Readout board model that collects output words
`timescale 1ns/1ps
module nfero_board_model (
  input wire i_clk, // Clock
  input wire i_valid, // Word valid
  input wire [12:0] i_sample, // Sample
  input wire [7:0] i_chan, // Channel
  input wire [31:0] i_ts, // Timestamp
  input wire i_slow, // Stall every other cycle
  output reg o_ready // Accept
);
  logic [52:0] q[$];
  initial o_ready = 1'b0;
  // Alternate stalls exercise held words
  always @(negedge i_clk) begin
    o_ready <= i_slow ? ~o_ready : 1'b1;
  end
  // Takes words only when offered; the crate decides when transfer may run
  always @(posedge i_clk) begin
    if (i_valid && o_ready) begin
      q.push_back({i_chan, i_sample, i_ts});
    end
  end
endmodule

// ===== testbench/nfero_top_tb.sv
// Self-checking bench for the near front-end readout control
`timescale 1ns/1ps
`include "nfero_defines.vh"
module nfero_top_tb;
  logic clk_sys = 1'b0, arst_n = 1'b0, spill = 1'b0, slow = 1'b0, ready, valid, ovf, busy;
  logic [1:0] mode = 2'h0, trig = 2'h0;
  logic [12:0] sample;
  logic [7:0] chan;
  logic [31:0] ts;
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  always #5 clk_sys = ~clk_sys;
  nfero_top u_nfero_top (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_mode(mode), .i_spill(spill),
    .i_dynode_trig(trig), .i_range_code(12'h040), .i_conv_value(32'h1080_4005), .i_threshold(13'h0010),
    .i_out_ready(ready), .o_out_valid(valid), .o_out_sample(sample), .o_out_chan(chan), .o_out_ts(ts),
    .o_overflow(ovf), .o_busy(busy));
  nfero_board_model u_nfero_board_model (.i_clk(clk_sys), .i_valid(valid), .i_sample(sample),
    .i_chan(chan), .i_ts(ts), .i_slow(slow), .o_ready(ready));
  task chk(input bit ok, input string msg);
    total_checks++;
    if (!ok) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task cyc_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task drain(input int n);
    int k;
    for (k = 0; k < 600 && !(u_nfero_board_model.q.size() >= n && !busy); k++) @(negedge clk_sys);
    cyc_n(8);
    chk(u_nfero_board_model.q.size() == n, "word count");
  endtask
  // Channel c0 upward, per words a set; only channels 1 and 2 pass the threshold
  task words(input int n, input int per, input logic [7:0] c0);
    logic [52:0] w;
    logic [31:0] t0;
    int i;
    t0 = u_nfero_board_model.q[0][31:0];
    for (i = 0; i < n; i++) begin
      w = u_nfero_board_model.q[i];
      chk(w[52:45] === c0 + i % per, "channel");
      chk(w[44:32] === {w[1:0], w[52:45] == 8'h01 ? 11'h040 : 11'h180}, "sample");
      chk(w[31:0] === t0 + i / per, "timestamp");
    end
    u_nfero_board_model.q.delete();
  endtask
  task t_single;
    mode = `NFERO_MODE_SINGLE;
    trig = 2'h3;
    spill = 1'b1;
    cyc_n(3);
    spill = 1'b0;
    cyc_n(6);
    trig = 2'h0;
    drain(6);
    words(6, 2, 8'h01);
    $display("single-turn test done");
  endtask
  task t_cosmic;
    mode = `NFERO_MODE_COSMIC;
    trig = 2'h1;
    cyc_n(1);
    trig = 2'h0;
    drain(1);
    words(1, 1, 8'h01);
    $display("cosmic test done");
  endtask
  task t_reson;
    mode = `NFERO_MODE_RESON;
    slow = 1'b1;
    spill = 1'b1;
    cyc_n(3);
    trig = 2'h2;
    cyc_n(1);
    trig = 2'h0;
    cyc_n(10);
    chk(u_nfero_board_model.q.size() == 0, "word during spill");
    spill = 1'b0;
    drain(4);
    words(4, 1, 8'h02);
    slow = 1'b0;
    $display("resonant test done");
  endtask
  task t_overflow;
    mode = `NFERO_MODE_SINGLE;
    chk(ovf === 1'b0, "early overflow");
    spill = 1'b1;
    cyc_n(20);
    spill = 1'b0;
    drain(32);
    chk(ovf === 1'b1, "overflow flag");
    words(32, 2, 8'h01);
    $display("overflow test done");
  endtask
  // Unused mode code: spill and triggers must store and send nothing
  task t_mode_off;
    mode = 2'h3;
    spill = 1'b1;
    trig = 2'h3;
    cyc_n(4);
    spill = 1'b0;
    cyc_n(4);
    trig = 2'h0;
    drain(0);
    chk(busy === 1'b0, "transfer in unused mode");
    $display("unused mode test done");
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      $display("[FAIL] %0t timeout", $time);
      print_verdict();
    end
  end
  initial begin
    cyc_n(5);
    arst_n = 1'b1;
    cyc_n(4);
    t_single();
    t_cosmic();
    t_reson();
    t_overflow();
    t_mode_off();
    print_verdict();
  end
endmodule
